// *** logic/cdw_cfg.svh ***
// constants for clock divide and watchdog block
`ifndef CDW_CFG_SVH
`define CDW_CFG_SVH
`define CDW_DIV_X       2'h0
`define CDW_DIV_RSVD    2'h1
`define CDW_DIV_1       2'h2
`define CDW_DIV_1024    2'h3
`define CDW_DIV_RST     2'h2
`define CDW_SLOW_DIV    11'h400
`define CDW_TMR_DIV     4'hC
`define CDW_WD_N_X4     6'h0F
`define CDW_WD_N_X2     6'h10
`define CDW_WD_N_X1     6'h11
`define CDW_WD_N_SLOW   6'h1B
`define CDW_WD_RATIO_RST 2'h0
`define CDW_WD_RST_LAG  10'h200
`define CDW_WD_LAG_X4   20'h00080
`define CDW_WD_LAG_X2   20'h00100
`define CDW_WD_LAG_SLOW 20'h80000
`define CDW_XTAL_WARM   17'h10000
`define CDW_MULT_WARM   17'h10000
`define CDW_TA_KEY1     8'hAA
`define CDW_TA_KEY2     8'h55
`define CDW_TA_WINDOW   2'h3
`endif

// *** logic/cdw_pkg.sv ***
// types for clock divide and watchdog block
`default_nettype none
package cdw_pkg;
   typedef struct packed {
      logic [1:0] clock_divide;
      logic       multiply_select;
      logic       multiplier_enable;
      logic       switchback_enable;
   } cdw_pmr_t;
   typedef struct packed {
      logic [1:0] watchdog_ratio;
      logic       watchdog_irq_enable;
      logic       watchdog_reset_enable;
   } cdw_wdcfg_t;
   typedef enum logic [1:0] {CDW_WARM, CDW_RUN} cdw_xstate_t;
endpackage
`default_nettype wire

// *** logic/cdw_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module cdw_sync (
   input  wire logic i_mclk,
   input  wire logic i_resetn,
   input  wire logic i_d,
   output logic      o_q
);
   logic meta_reg;
   logic meta_next;
   logic q_next;
   always_comb begin
      meta_next = i_d;
      q_next    = meta_reg;
   end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_reg <= 1'b1; // idle high line, no false edge
         o_q      <= 1'b1;
      end else begin
         meta_reg <= meta_next;
         o_q      <= q_next;
      end
   end
endmodule
`default_nettype wire

// *** logic/cdw_top.sv ***
// clock divide control, multiplier startup, crystal warm-up and watchdog
`timescale 1ns/1ps
`default_nettype none
`include "cdw_cfg.svh"
// Operation
// - divide code 01 behaves as divide-by-1 like code 10
// - every reset returns divide field to divide-by-1
// - slow clock is oscillator divided by 1024
// - divide code 11 selects 1024 oscillator cycles per machine cycle
// - slow mode with switchback set returns to divide-by-1 on start bit
// - other modes ignore interrupts and serial activity
// - timer prescale 00 gets oscillator divided by 12 at ratios 4,2,1
// - multiplied clock refused until multiplier_ready set
// - multiply_select writable only while multiplier_enable is 0
// - multiplier_enable writable only in divide-by-1 with ring_osc_mode 0
// - enabling multiplier clears ready and starts startup counter
// - during startup ready stays 0 and divide 00 refused
// - multiplier_enable cleared on every reset
// - reset gives default ratio: 2^17 timeout, reset 512 later
// - ratio selects 2^(n+3k) timeout, n by clock mode
// - watchdog reset comes 512 system clocks after interrupt timeout
// - restart begins a new interval; reset enable lets timeout reset
// - without restarts interrupt timeouts repeat at programmed ratio
// - flags set on interval expiry and on watchdog reset
// - interrupt forwarded only with watchdog_irq_enable
// - watchdog counts oscillator cycles, limits scaled to system clocks
// - crystal counts 65536 cycles before becoming system clock
// - multiplier startup timed by its own counter when enabled
// - watchdog interrupt wakes core from idle
module cdw_top #(
   parameter int XTAL_WARM = `CDW_XTAL_WARM,
   parameter int MULT_WARM = `CDW_MULT_WARM
) (
   input  wire logic            i_mclk,
   input  wire logic            i_resetn,
   input  wire logic            i_xtal_restart,
   input  wire logic            i_ring_osc_mode,
   input  wire logic            i_rx_start_pin_n,
   input  wire logic            i_pmr_we,
   input  wire cdw_pkg::cdw_pmr_t i_pmr_wdata,
   input  wire logic            i_wd_we,
   input  wire cdw_pkg::cdw_wdcfg_t i_wd_wdata,
   input  wire logic            i_ta_we,
   input  wire logic [7:0]      i_ta_wdata,
   input  wire logic            i_wd_restart,
   input  wire logic            i_flag_we,
   input  wire logic [1:0]      i_flag_wdata,
   input  wire logic            i_idle,
   output var cdw_pkg::cdw_pmr_t o_pmr,
   output var cdw_pkg::cdw_wdcfg_t o_wdcfg,
   output logic                 o_multiplier_ready,
   output logic                 o_xtal_ready,
   output logic                 o_sys_tick,
   output logic                 o_timer_tick,
   output logic                 o_watchdog_irq_flag,
   output logic                 o_watchdog_reset_flag,
   output logic                 o_watchdog_irq,
   output logic                 o_watchdog_reset,
   output logic                 o_idle_wake
);
   if (XTAL_WARM < 1 || XTAL_WARM > 131071 || MULT_WARM < 1 || MULT_WARM > 131071) begin : g_bad_warm
      $error("cdw_top: warm-up counts out of range");
   end
   localparam logic [16:0] XW = 17'(XTAL_WARM - 1);
   localparam logic [16:0] MW = 17'(MULT_WARM - 1);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser
   logic rx_n;
   logic rx_prev_reg;
   logic rx_prev_next;
   cdw_sync u_rx (
      .i_mclk   (i_mclk),
      .i_resetn (i_resetn),
      .i_d      (i_rx_start_pin_n),
      .o_q      (rx_n)
   );
   ////////////////////////////////////////////////////////////////////////////
   // clock control state
   cdw_pkg::cdw_pmr_t   pmr_reg;
   cdw_pkg::cdw_pmr_t   pmr_next;
   logic                mrdy_reg;
   logic                mrdy_next;
   logic [16:0]         mcnt_reg;
   logic [16:0]         mcnt_next;
   cdw_pkg::cdw_xstate_t xst_reg;
   cdw_pkg::cdw_xstate_t xst_next;
   logic [16:0]         xcnt_reg;
   logic [16:0]         xcnt_next;
   logic                start_bit;
   always_comb begin
      pmr_next     = pmr_reg;
      mrdy_next    = mrdy_reg;
      mcnt_next    = mcnt_reg;
      xst_next     = xst_reg;
      xcnt_next    = xcnt_reg;
      rx_prev_next = rx_n;
      start_bit    = rx_prev_reg & ~rx_n;
      case (xst_reg)
         cdw_pkg::CDW_WARM: begin
            if (xcnt_reg == XW) begin
               xst_next = cdw_pkg::CDW_RUN;
            end else begin
               xcnt_next = xcnt_reg + 17'h1;
            end
         end
         cdw_pkg::CDW_RUN: begin
            if (i_xtal_restart) begin
               xst_next  = cdw_pkg::CDW_WARM;
               xcnt_next = 17'h0;
            end
         end
         default: xst_next = cdw_pkg::CDW_WARM;
      endcase
      if (pmr_reg.multiplier_enable && !mrdy_reg) begin
         if (mcnt_reg == MW) begin
            mrdy_next = 1'b1;
         end else begin
            mcnt_next = mcnt_reg + 17'h1;
         end
      end
      if (i_pmr_we) begin
         pmr_next.switchback_enable = i_pmr_wdata.switchback_enable;
         if (!(i_pmr_wdata.clock_divide == `CDW_DIV_X && !mrdy_reg)) begin
            pmr_next.clock_divide = i_pmr_wdata.clock_divide;
         end
         if (!pmr_reg.multiplier_enable) begin
            pmr_next.multiply_select = i_pmr_wdata.multiply_select;
         end
         if ((pmr_reg.clock_divide == `CDW_DIV_1 || pmr_reg.clock_divide == `CDW_DIV_RSVD)
             && !i_ring_osc_mode) begin
            pmr_next.multiplier_enable = i_pmr_wdata.multiplier_enable;
            if (i_pmr_wdata.multiplier_enable && !pmr_reg.multiplier_enable) begin
               mrdy_next = 1'b0;
               mcnt_next = 17'h0;
            end
         end
         if (!pmr_next.multiplier_enable) begin
            mrdy_next = 1'b0;
         end
      end
      // only slow mode reacts to the receive start bit
      if (pmr_reg.clock_divide == `CDW_DIV_1024 && pmr_reg.switchback_enable && start_bit) begin
         pmr_next.clock_divide = `CDW_DIV_1;
      end
   end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         pmr_reg     <= '{clock_divide: `CDW_DIV_RST, default: 1'b0};
         mrdy_reg    <= 1'b0;
         mcnt_reg    <= 17'h0;
         xst_reg     <= cdw_pkg::CDW_WARM;
         xcnt_reg    <= 17'h0;
         rx_prev_reg <= 1'b1;
      end else begin
         pmr_reg     <= pmr_next;
         mrdy_reg    <= mrdy_next;
         mcnt_reg    <= mcnt_next;
         xst_reg     <= xst_next;
         xcnt_reg    <= xcnt_next;
         rx_prev_reg <= rx_prev_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // machine-cycle and timer ticks
   logic [10:0] slow_reg;
   logic [10:0] slow_next;
   logic [3:0]  tdiv_reg;
   logic [3:0]  tdiv_next;
   logic        stick_reg;
   logic        stick_next;
   logic        ttick_reg;
   logic        ttick_next;
   logic        slow_mode;
   always_comb begin
      slow_mode  = (pmr_reg.clock_divide == `CDW_DIV_1024);
      slow_next  = (slow_reg == `CDW_SLOW_DIV - 11'h1) ? 11'h0 : slow_reg + 11'h1;
      tdiv_next  = (tdiv_reg == `CDW_TMR_DIV - 4'h1) ? 4'h0 : tdiv_reg + 4'h1;
      // codes 01 and 10 both tick every oscillator cycle
      stick_next = (xst_reg == cdw_pkg::CDW_RUN) && (!slow_mode || slow_reg == 11'h0);
      ttick_next = slow_mode ? stick_next : (xst_reg == cdw_pkg::CDW_RUN) && tdiv_reg == 4'h0;
   end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         slow_reg  <= 11'h0;
         tdiv_reg  <= 4'h0;
         stick_reg <= 1'b0;
         ttick_reg <= 1'b0;
      end else begin
         slow_reg  <= slow_next;
         tdiv_reg  <= tdiv_next;
         stick_reg <= stick_next;
         ttick_reg <= ttick_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // timed access and watchdog
   cdw_pkg::cdw_wdcfg_t wcfg_reg;
   cdw_pkg::cdw_wdcfg_t wcfg_next;
   logic [1:0]  ta_st_reg;
   logic [1:0]  ta_st_next;
   logic [1:0]  ta_cnt_reg;
   logic [1:0]  ta_cnt_next;
   logic [36:0] wcnt_reg;
   logic [36:0] wcnt_next;
   logic [19:0] lag_reg;
   logic [19:0] lag_next;
   logic        lag_run_reg;
   logic        lag_run_next;
   logic        wif_reg;
   logic        wif_next;
   logic        wrf_reg;
   logic        wrf_next;
   logic        wrst_reg;
   logic        wrst_next;
   logic        unlocked;
   logic        restart;
   logic [5:0]  wd_exp;
   logic [36:0] wd_limit;
   logic [19:0] lag_limit;
   logic        expire;
   always_comb begin
      wcfg_next    = wcfg_reg;
      ta_st_next   = ta_st_reg;
      ta_cnt_next  = ta_cnt_reg;
      wcnt_next    = wcnt_reg;
      lag_next     = lag_reg;
      lag_run_next = lag_run_reg;
      wif_next     = wif_reg;
      wrf_next     = wrf_reg;
      wrst_next    = 1'b0;
      unlocked     = (ta_st_reg == 2'h2);
      // unlock window after the key pair
      if (ta_st_reg != 2'h0) begin
         ta_cnt_next = ta_cnt_reg + 2'h1;
         if (ta_cnt_reg == `CDW_TA_WINDOW - 2'h1) begin
            ta_st_next = 2'h0;
         end
      end
      if (i_ta_we) begin
         ta_cnt_next = 2'h0;
         if (i_ta_wdata == `CDW_TA_KEY1) begin
            ta_st_next = 2'h1;
         end else if (i_ta_wdata == `CDW_TA_KEY2 && ta_st_reg == 2'h1) begin
            ta_st_next = 2'h2;
         end else begin
            ta_st_next = 2'h0;
         end
      end
      restart = i_wd_restart && unlocked;
      if (i_wd_we) begin
         wcfg_next.watchdog_ratio      = i_wd_wdata.watchdog_ratio;
         wcfg_next.watchdog_irq_enable = i_wd_wdata.watchdog_irq_enable;
         if (unlocked) begin
            wcfg_next.watchdog_reset_enable = i_wd_wdata.watchdog_reset_enable;
         end
      end
      case (pmr_reg.clock_divide)
         `CDW_DIV_X:    wd_exp = pmr_reg.multiply_select ? `CDW_WD_N_X4 : `CDW_WD_N_X2;
         `CDW_DIV_1024: wd_exp = `CDW_WD_N_SLOW;
         default:       wd_exp = `CDW_WD_N_X1;
      endcase
      wd_exp    = wd_exp + 6'(3 * wcfg_reg.watchdog_ratio);
      wd_limit  = 37'h1 << wd_exp;
      // lag is 512 system clocks counted in oscillator cycles
      case (pmr_reg.clock_divide)
         `CDW_DIV_X:    lag_limit = pmr_reg.multiply_select ? `CDW_WD_LAG_X4 : `CDW_WD_LAG_X2;
         `CDW_DIV_1024: lag_limit = `CDW_WD_LAG_SLOW;
         default:       lag_limit = 20'(`CDW_WD_RST_LAG);
      endcase
      expire = (wcnt_reg >= wd_limit - 37'h1);
      if (xst_reg == cdw_pkg::CDW_RUN) begin
         wcnt_next = expire ? 37'h0 : wcnt_reg + 37'h1;
      end
      if (expire && xst_reg == cdw_pkg::CDW_RUN) begin
         lag_run_next = 1'b1;
         lag_next     = 20'h0;
      end else if (lag_run_reg) begin
         lag_next = lag_reg + 20'h1;
         if (lag_reg >= lag_limit - 20'h1) begin
            lag_run_next = 1'b0;
            if (wcfg_reg.watchdog_reset_enable) begin
               wrst_next = 1'b1;
            end
         end
      end
      if (restart) begin
         wcnt_next    = 37'h0;
         lag_run_next = 1'b0;
      end
      // hardware set wins over software clear
      if (i_flag_we && unlocked && !i_flag_wdata[1]) begin
         wif_next = 1'b0;
      end
      if (i_flag_we && !i_flag_wdata[0]) begin
         wrf_next = 1'b0;
      end
      if (expire && xst_reg == cdw_pkg::CDW_RUN) begin
         wif_next = 1'b1;
      end
      if (wrst_next) begin
         wrf_next = 1'b1;
      end
   end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         wcfg_reg    <= '{watchdog_ratio: `CDW_WD_RATIO_RST, default: 1'b0};
         ta_st_reg   <= 2'h0;
         ta_cnt_reg  <= 2'h0;
         wcnt_reg    <= 37'h0;
         lag_reg     <= 20'h0;
         lag_run_reg <= 1'b0;
         wif_reg     <= 1'b0;
         wrf_reg     <= 1'b0;
         wrst_reg    <= 1'b0;
      end else begin
         wcfg_reg    <= wcfg_next;
         ta_st_reg   <= ta_st_next;
         ta_cnt_reg  <= ta_cnt_next;
         wcnt_reg    <= wcnt_next;
         lag_reg     <= lag_next;
         lag_run_reg <= lag_run_next;
         wif_reg     <= wif_next;
         wrf_reg     <= wrf_next;
         wrst_reg    <= wrst_next;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pmr                 <= '{clock_divide: `CDW_DIV_RST, default: 1'b0};
         o_wdcfg               <= '{watchdog_ratio: `CDW_WD_RATIO_RST, default: 1'b0};
         o_multiplier_ready    <= 1'b0;
         o_xtal_ready          <= 1'b0;
         o_sys_tick            <= 1'b0;
         o_timer_tick          <= 1'b0;
         o_watchdog_irq_flag   <= 1'b0;
         o_watchdog_reset_flag <= 1'b0;
         o_watchdog_irq        <= 1'b0;
         o_watchdog_reset      <= 1'b0;
         o_idle_wake           <= 1'b0;
      end else begin
         o_pmr                 <= pmr_reg;
         o_wdcfg               <= wcfg_reg;
         o_multiplier_ready    <= mrdy_reg;
         o_xtal_ready          <= (xst_reg == cdw_pkg::CDW_RUN);
         o_sys_tick            <= stick_reg;
         o_timer_tick          <= ttick_reg;
         o_watchdog_irq_flag   <= wif_reg;
         o_watchdog_reset_flag <= wrf_reg;
         o_watchdog_irq        <= wif_reg && wcfg_reg.watchdog_irq_enable;
         o_watchdog_reset      <= wrst_reg;
         o_idle_wake           <= i_idle && wif_reg && wcfg_reg.watchdog_irq_enable;
      end
   end
endmodule
`default_nettype wire

// *** verification/cdw_top_assertions.sv ***
// assertion checker for clock divide and watchdog block
`timescale 1ns/1ps
`default_nettype none
module cdw_top_chk #(
   parameter int XTAL_WARM = 65536,
   parameter int MULT_WARM = 65536
) (
   input wire logic                i_mclk,
   input wire logic                i_resetn,
   input wire logic                i_pmr_we,
   input wire cdw_pkg::cdw_pmr_t   o_pmr,
   input wire cdw_pkg::cdw_wdcfg_t o_wdcfg,
   input wire logic                o_multiplier_ready,
   input wire logic                o_xtal_ready,
   input wire logic                o_watchdog_reset_flag,
   input wire logic                o_watchdog_reset
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_cold; !o_xtal_ready [*8]; endsequence
   sequence s_warm; ##[0:40] o_xtal_ready; endsequence
   sequence s_unready; !o_multiplier_ready [*8]; endsequence
   sequence s_rflag; ##[1:3] o_watchdog_reset_flag; endsequence
   property p_rst_vals; $rose(i_resetn) |-> o_pmr == 5'h10 && o_wdcfg == 4'h0; endproperty
   a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
   property p_sel_lock; $changed(o_pmr.multiply_select) |-> !$past(o_pmr.multiplier_enable);
   endproperty
   a_sel_lock: assert property (p_sel_lock) else $error("select moved while enabled");
   property p_en_gate;
      $rose(o_pmr.multiplier_enable) |-> $past(o_pmr.clock_divide) inside {2'h1, 2'h2};
   endproperty
   a_en_gate: assert property (p_en_gate) else $error("enable taken off divide-by-1");
   property p_fast_ready; o_pmr.clock_divide == 2'h0 |-> o_multiplier_ready; endproperty
   a_fast_ready: assert property (p_fast_ready) else $error("fast clock before ready");
   property p_warm; $rose(o_pmr.multiplier_enable) |-> s_unready; endproperty
   a_warm: assert property (p_warm) else $error("ready too early");
   property p_ready; $rose(o_pmr.multiplier_enable) |-> ##[1:40] o_multiplier_ready; endproperty
   a_ready: assert property (p_ready) else $error("ready never came");
   property p_div_hold;
      $changed(o_pmr.clock_divide) |-> $past(i_pmr_we) || $past(i_pmr_we, 2)
         || $past(i_pmr_we, 3) || $past(o_pmr.clock_divide) == 2'h3;
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divide moved by itself");
   property p_rst_en; o_watchdog_reset |-> o_wdcfg.watchdog_reset_enable; endproperty
   a_rst_en: assert property (p_rst_en) else $error("reset while masked");
   property p_rflag; o_watchdog_reset |-> s_rflag; endproperty
   a_rflag: assert property (p_rflag) else $error("reset flag missing");
   property p_xtal; $rose(i_resetn) |-> s_cold ##1 s_warm; endproperty
   a_xtal: assert property (p_xtal) else $error("crystal warm-up wrong");
endmodule
bind cdw_top cdw_top_chk #(.XTAL_WARM(XTAL_WARM), .MULT_WARM(MULT_WARM)) u_chk (
   .i_mclk, .i_resetn, .i_pmr_we, .o_pmr, .o_wdcfg, .o_multiplier_ready, .o_xtal_ready,
   .o_watchdog_reset_flag, .o_watchdog_reset);
`default_nettype wire

// *** verification/cdw_far_end.sv ***
// serial line, crystal restart and reset counter on the far side
`timescale 1ns/1ps
`default_nettype none
module cdw_far_end #(
   parameter int BIT_CYC = 8
) (
   input  wire logic  i_mclk,
   input  wire logic  i_send,
   input  wire logic  i_stop_exit,
   input  wire logic  i_wd_reset,
   output logic       o_rx_n,
   output logic       o_xtal_restart,
   output logic [7:0] o_resets
);
   int bit_cnt = 0;
   initial o_resets = 8'h00;
   initial o_xtal_restart = 1'b0;
   always @(posedge i_mclk) begin
      o_xtal_restart <= i_stop_exit;
      if (i_wd_reset) begin
         o_resets <= o_resets + 8'h01;
      end
      if (i_send && bit_cnt == 0) begin
         bit_cnt <= BIT_CYC;
      end else if (bit_cnt != 0) begin
         bit_cnt <= bit_cnt - 1;
      end
   end
   // line pulled high, low only for the start bit
   assign o_rx_n = (bit_cnt == 0);
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for clock divide and watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   typedef struct {logic [1:0] div; int sys; int tmr;} cdw_row_t;
   cdw_row_t rows [3] = '{'{2'h2, 1, 12}, '{2'h1, 1, 12}, '{2'h3, 1024, 1024}};
   logic i_mclk = 1'b0, i_resetn = 1'b0, i_ring_osc_mode = 1'b0, i_idle = 1'b0;
   logic i_pmr_we = 1'b0, i_wd_we = 1'b0, i_ta_we = 1'b0, i_wd_restart = 1'b0;
   logic i_flag_we = 1'b0, send = 1'b0, stop_exit = 1'b0;
   logic [7:0] i_ta_wdata = 8'h00;
   logic [1:0] i_flag_wdata = 2'h0;
   cdw_pkg::cdw_pmr_t   i_pmr_wdata = '0, o_pmr;
   cdw_pkg::cdw_wdcfg_t i_wd_wdata = '0, o_wdcfg;
   wire logic i_xtal_restart, i_rx_start_pin_n, o_multiplier_ready, o_xtal_ready;
   wire logic o_sys_tick, o_timer_tick, o_watchdog_irq_flag, o_watchdog_reset_flag;
   wire logic o_watchdog_irq, o_watchdog_reset, o_idle_wake;
   wire logic [7:0] resets;
   int n_fail = 0, compares = 0, p, n;
   always #4 i_mclk = ~i_mclk;
   cdw_top #(.XTAL_WARM(16), .MULT_WARM(16)) DUT (.i_mclk, .i_resetn, .i_xtal_restart,
      .i_ring_osc_mode, .i_rx_start_pin_n, .i_pmr_we, .i_pmr_wdata, .i_wd_we, .i_wd_wdata,
      .i_ta_we, .i_ta_wdata, .i_wd_restart, .i_flag_we, .i_flag_wdata, .i_idle, .o_pmr,
      .o_wdcfg, .o_multiplier_ready, .o_xtal_ready, .o_sys_tick, .o_timer_tick,
      .o_watchdog_irq_flag, .o_watchdog_reset_flag, .o_watchdog_irq, .o_watchdog_reset,
      .o_idle_wake);
   cdw_far_end u_far (.i_mclk, .i_send(send), .i_stop_exit(stop_exit),
      .i_wd_reset(o_watchdog_reset), .o_rx_n(i_rx_start_pin_n),
      .o_xtal_restart(i_xtal_restart), .o_resets(resets));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge i_mclk);
   endtask
   task automatic wr(input int k, input logic [7:0] d);
      @(negedge i_mclk);
      {i_pmr_we, i_wd_we, i_ta_we, i_wd_restart, i_flag_we} = 5'h10 >> k;
      i_pmr_wdata = d[4:0];
      i_wd_wdata = d[3:0];
      i_ta_wdata = d;
      i_flag_wdata = d[1:0];
      @(negedge i_mclk);
      {i_pmr_we, i_wd_we, i_ta_we, i_wd_restart, i_flag_we} = 5'h00;
   endtask
   task automatic unl;
      wr(2, 8'hAA);
      wr(2, 8'h55);
   endtask
   task automatic rx;
      send = 1'b1;
      cyc(1);
      send = 1'b0;
      cyc(20);
   endtask
   task automatic wt(input int k, input int lim, output int c);
      logic [3:0] s;
      c = 0;
      s = {o_xtal_ready, o_watchdog_reset, o_watchdog_irq_flag, o_multiplier_ready};
      while (s[k] !== 1'b1 && c < lim) begin
         cyc(1);
         c++;
         s = {o_xtal_ready, o_watchdog_reset, o_watchdog_irq_flag, o_multiplier_ready};
      end
   endtask
   task automatic per(input int k, output int c);
      c = 0;
      while ((k == 1 ? o_timer_tick : o_sys_tick) !== 1'b1 && c < 3000) begin
         cyc(1);
         c++;
      end
      c = 0;
      do begin
         cyc(1);
         c++;
      end while ((k == 1 ? o_timer_tick : o_sys_tick) !== 1'b1 && c < 3000);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #600000;
      n_fail++;
      wrap_up;
   end
   initial begin
      cyc(3);
      i_resetn = 1'b1;
      cyc(30);
      chk(o_xtal_ready, 1'b1);
      foreach (rows[r]) begin
         wr(0, {3'h0, rows[r].div, 3'h0});
         cyc(4);
         chk(o_pmr.clock_divide, rows[r].div);
         per(4, p);
         chk(p, rows[r].sys);
         per(1, p);
         chk(p, rows[r].tmr);
      end
      rx;
      chk(o_pmr.clock_divide, 2'h3);
      wr(0, 8'h19);
      cyc(4);
      rx;
      chk(o_pmr.clock_divide, 2'h2);
      rx;
      chk(o_pmr.clock_divide, 2'h2);
      i_ring_osc_mode = 1'b1;
      wr(0, 8'h16);
      cyc(4);
      chk(o_pmr, 5'h14);
      i_ring_osc_mode = 1'b0;
      wr(0, 8'h16);
      wr(0, 8'h06);
      wr(0, 8'h12);
      cyc(4);
      chk(o_pmr, 5'h16);
      chk(o_multiplier_ready, 1'b0);
      wt(0, 100, n);
      chk(o_multiplier_ready, 1'b1);
      wr(0, 8'h06);
      cyc(4);
      chk(o_pmr.clock_divide, 2'h0);
      per(1, p);
      chk(p, 12);
      wr(1, 8'h03);
      wr(2, 8'hAA);
      wr(2, 8'h12);
      wr(2, 8'h55);
      wr(1, 8'h03);
      cyc(4);
      chk(o_wdcfg, 4'h2);
      unl;
      wr(1, 8'h03);
      cyc(4);
      chk(o_wdcfg, 4'h3);
      i_idle = 1'b1;
      unl;
      wr(3, 8'h00);
      wt(1, 40000, n);
      chk(n >= 32766 && n <= 32772, 1'b1);
      wt(2, 400, n);
      chk(n >= 122 && n <= 132, 1'b1);
      cyc(4);
      chk({o_watchdog_reset_flag, o_watchdog_irq, o_idle_wake}, 3'h7);
      chk(resets, 8'h01);
      wr(4, 8'h00);
      cyc(4);
      chk(o_watchdog_irq_flag, 1'b1);
      wr(1, 8'h01);
      cyc(4);
      chk({o_watchdog_irq, o_idle_wake}, 2'h0);
      unl;
      wr(4, 8'h00);
      cyc(4);
      chk({o_watchdog_irq_flag, o_watchdog_reset_flag}, 2'h0);
      stop_exit = 1'b1;
      cyc(1);
      stop_exit = 1'b0;
      cyc(3);
      chk(o_xtal_ready, 1'b0);
      wt(3, 100, n);
      chk(o_xtal_ready, 1'b1);
      i_resetn = 1'b0;
      cyc(2);
      chk(o_pmr, 5'h10);
      chk(o_wdcfg, 4'h0);
      i_resetn = 1'b1;
      cyc(30);
      chk(o_pmr, 5'h10);
      wrap_up;
   end
endmodule
`default_nettype wire
